// file: ccdt_cfg.svh
// constants for the ccd acquisition and strobe controller
`ifndef CCDT_CFG_SVH
`define CCDT_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCDT_CLK_NS 25
`define CCDT_TICK_NS 500
`define CCDT_TICK_CYC (`CCDT_TICK_NS / `CCDT_CLK_NS)
// detector transfer and reset, least time of the 8 to 9 us span
`define CCDT_GATE_NS 8000
`define CCDT_GATE_CYC ((`CCDT_GATE_NS + `CCDT_CLK_NS - 1) / `CCDT_CLK_NS)
`define CCDT_STROBE_SAT 17'h10000
`define CCDT_CSTROBE_MIN 27'h0000004

// ----------------------------------------------------------------
// detector pixel layout
// ----------------------------------------------------------------
`define CCDT_ELEM_FIRST 12'h00C
`define CCDT_ELEM_LAST 12'h825
`define CCDT_SPEC_LAST 12'h7FF
`define CCDT_SCANS_PER_REQ 2'h3

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CCDT_OFS_CTRL 8'h00
`define CCDT_OFS_INT 8'h04
`define CCDT_OFS_RISE 8'h08
`define CCDT_OFS_FALL 8'h0C
`define CCDT_OFS_TDLY 8'h10
`define CCDT_OFS_CPER 8'h14
`define CCDT_OFS_CMD 8'h18
`define CCDT_OFS_STAT 8'h1C
`define CCDT_OFS_PADDR 8'h20
`define CCDT_OFS_PDATA 8'h24

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CCDT_CTRL_LAMP 3
`define CCDT_CMD_REQ 0
`define CCDT_CMD_REL 1
`define CCDT_INT_RST 32'h000007D0
`define CCDT_CPER_RST 27'h0000004

`endif

// file: ccdt_pkg.sv
// types shared by the acquisition controller files
`default_nettype none
package ccdt_pkg;
  // acquisition sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_GATE,
    ST_INTEG
  } ccdt_state_t;

  // trigger modes in software encoding order
  typedef enum logic [2:0] {
    MODE_FREE,
    MODE_SOFT,
    MODE_SYNC,
    MODE_LEVEL,
    MODE_EDGE
  } ccdt_mode_t;
endpackage : ccdt_pkg
`default_nettype wire

// file: ccdt_mem_if.sv
// spectrum memory port bundle
`timescale 1ns/1ps
`default_nettype none
interface ccdt_mem_if #(
  parameter int AW = 11,
  parameter int DW = 14
) ();
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface : ccdt_mem_if
`default_nettype wire

// file: ccdt_mem.sv
// one spectrum of delivered pixels, registered read
`timescale 1ns/1ps
`default_nettype none
module ccdt_mem #(
  parameter int AW = 11,
  parameter int DW = 14
) (
  input wire logic i_mclk,
  ccdt_mem_if.mem bus
);
  logic [DW-1:0] ram [0:(1<<AW)-1];

  // write port and read register; no reset so it maps to block ram
  always_ff @(posedge i_mclk) begin
    if (bus.wr_en) begin
      ram[bus.wr_addr] <= bus.wr_data;
    end
    bus.rd_data <= ram[bus.rd_addr];
  end
endmodule : ccdt_mem
`default_nettype wire

// file: ccdt_cstrobe.sv
// free running square wave strobe on the 500 ns timebase
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_cfg.svh"
module ccdt_cstrobe #(
  parameter int PW = 27
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic [PW-1:0] i_period,
  input wire logic i_lamp,
  output logic o_strobe
);
  logic [PW-1:0] cnt_r, cnt_nxt;
  logic phase_r, phase_nxt;
  logic out_r, out_nxt;
  logic [PW-1:0] half;

  // half period in ticks; periods under 2 us are clamped up
  assign half = (i_period < `CCDT_CSTROBE_MIN) ?
    PW'(`CCDT_CSTROBE_MIN >> 1) : (i_period >> 1);

  // divider: toggles every half period, never tied to acquisition
  always_comb begin
    cnt_nxt = cnt_r;
    phase_nxt = phase_r;
    if (!i_lamp) begin
      cnt_nxt = '0;
      phase_nxt = 1'b0;
    end else if (i_tick) begin
      if (cnt_r + 1'b1 >= half) begin
        cnt_nxt = '0;
        phase_nxt = !phase_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
    out_nxt = i_lamp && phase_nxt;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      phase_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      out_r <= out_nxt;
    end
  end

  assign o_strobe = out_r;
endmodule : ccdt_cstrobe
`default_nettype wire

// file: ccdt_top.sv
// acquisition timing, trigger modes, strobes and pixel capture
//
// What this block does
// - continuous strobe comes from dividing the master clock
// - lamp output is high while the lamp command is set
// - only 2048 detector pixels per scan are kept; the rest dropped
// - detector: 0-11 unused, 12-29 shielded, 32-2079 light, rest unused
// - delivered index equals detector element minus twelve
// - each integration start transfers charge and resets pixels, ~8 us
// - single strobe rises at rise delay, falls at fall delay
// - rise and fall delays are 16-bit counts of 500 ns
// - single strobe only while lamp is on
// - integration start is the readout gate rising edge
// - external modes wait a programmed trigger delay in 500 ns steps, on the edge that leaves idle only
// - continuous strobe is 50% square wave, 2 us to 60 s period
// - continuous strobe only while lamp is on
// - free run plus four trigger modes, chosen by mode field
// - free run scans two more after one; keeps one if requested
// - idle free run starts on request, never while spectrum unread
// - software mode scans always, hands over data when trigger high
// - sync mode: each trigger edge ends one integration, starts next
// - level mode: edge starts, scans repeat while trigger stays high
// - edge mode: one integration per trigger pulse
// - edge mode: unrequested data dropped, new trigger and request
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_cfg.svh"
module ccdt_top #(
  parameter int PIX_AW = 11,
  parameter int PIX_DW = 14,
  parameter int CPER_W = 27
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_trig,
  input wire logic i_pix_valid,
  input wire logic [PIX_DW-1:0] i_pix_data,
  output logic o_readout_gate,
  output logic o_integration_start,
  output logic o_strobe_single,
  output logic o_strobe_cont,
  output logic o_lamp_en
);
  import ccdt_pkg::*;

  // maps a detector element to its delivered index
  function automatic logic [PIX_AW-1:0] pix_map(input logic [11:0] e);
    logic [11:0] d;
    d = e - `CCDT_ELEM_FIRST;
    return d[PIX_AW-1:0];
  endfunction : pix_map

  ccdt_mem_if #(.AW(PIX_AW), .DW(PIX_DW)) u_mif ();

  // ----------------------------------------------------------------
  // timebase and trigger synchroniser
  // ----------------------------------------------------------------
  logic [4:0] tcnt_r, tcnt_nxt;
  logic tick_r, tick_nxt;
  logic trig_s1_r, trig_s2_r, trig_d_r;
  logic trig_rise;

  // 500 ns tick from the 40 MHz clock
  always_comb begin
    tick_nxt = (tcnt_r == 5'(`CCDT_TICK_CYC - 1));
    tcnt_nxt = tick_nxt ? 5'h00 : tcnt_r + 5'h01;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tcnt_r <= 5'h00;
      tick_r <= 1'b0;
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tick_r <= tick_nxt;
      trig_s1_r <= i_trig;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  // edge on the synchronised trigger only
  assign trig_rise = trig_s2_r && !trig_d_r;

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  logic [2:0] mode_r, mode_nxt;
  logic lamp_r, lamp_nxt;
  logic [31:0] int_r, int_nxt;
  logic [15:0] rise_r, rise_nxt, fall_r, fall_nxt, tdly_r, tdly_nxt;
  logic [CPER_W-1:0] cper_r, cper_nxt;
  logic [PIX_AW-1:0] paddr_r, paddr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic cmd_req, cmd_rel, access;
  ccdt_state_t st_r, st_nxt;
  logic ready_r, ready_nxt, req_r, req_nxt;

  assign access = i_psel && i_penable && !pready_r;

  // one wait state: answer registered in the first access cycle
  always_comb begin
    mode_nxt = mode_r;
    lamp_nxt = lamp_r;
    int_nxt = int_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    tdly_nxt = tdly_r;
    cper_nxt = cper_r;
    paddr_nxt = paddr_r;
    prdata_nxt = prdata_r;
    pready_nxt = access;
    pslverr_nxt = 1'b0;
    cmd_req = 1'b0;
    cmd_rel = 1'b0;
    if (access) begin
      prdata_nxt = 32'h00000000;
      case (i_paddr)
        `CCDT_OFS_CTRL: begin
          prdata_nxt = {28'h0000000, lamp_r, mode_r};
          if (i_pwrite) begin
            mode_nxt = i_pwdata[2:0];
            lamp_nxt = i_pwdata[`CCDT_CTRL_LAMP];
          end
        end
        `CCDT_OFS_INT: begin
          prdata_nxt = int_r;
          if (i_pwrite) int_nxt = i_pwdata;
        end
        `CCDT_OFS_RISE: begin
          prdata_nxt = {16'h0000, rise_r};
          if (i_pwrite) rise_nxt = i_pwdata[15:0];
        end
        `CCDT_OFS_FALL: begin
          prdata_nxt = {16'h0000, fall_r};
          if (i_pwrite) fall_nxt = i_pwdata[15:0];
        end
        `CCDT_OFS_TDLY: begin
          prdata_nxt = {16'h0000, tdly_r};
          if (i_pwrite) tdly_nxt = i_pwdata[15:0];
        end
        `CCDT_OFS_CPER: begin
          prdata_nxt = 32'(cper_r);
          if (i_pwrite) cper_nxt = i_pwdata[CPER_W-1:0];
        end
        `CCDT_OFS_CMD: begin
          cmd_req = i_pwrite && i_pwdata[`CCDT_CMD_REQ];
          cmd_rel = i_pwrite && i_pwdata[`CCDT_CMD_REL];
        end
        `CCDT_OFS_STAT: begin
          prdata_nxt = {27'h0000000, trig_s2_r, st_r, req_r, ready_r};
        end
        `CCDT_OFS_PADDR: begin
          prdata_nxt = 32'(paddr_r);
          if (i_pwrite) paddr_nxt = i_pwdata[PIX_AW-1:0];
        end
        `CCDT_OFS_PDATA: begin
          // read data was fetched for paddr_r ahead of this access
          prdata_nxt = 32'(u_mif.rd_data);
          if (!i_pwrite) paddr_nxt = paddr_r + 1'b1;
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= 3'h0;
      lamp_r <= 1'b0;
      int_r <= `CCDT_INT_RST;
      rise_r <= 16'h0000;
      fall_r <= 16'h0000;
      tdly_r <= 16'h0000;
      cper_r <= CPER_W'(`CCDT_CPER_RST);
      paddr_r <= '0;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      lamp_r <= lamp_nxt;
      int_r <= int_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      tdly_r <= tdly_nxt;
      cper_r <= cper_nxt;
      paddr_r <= paddr_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // acquisition sequencer
  // ----------------------------------------------------------------
  logic [31:0] cnt_r, cnt_nxt;
  logic [8:0] gcnt_r, gcnt_nxt;
  logic [1:0] extra_r, extra_nxt;
  logic cont_r, cont_nxt;
  logic keep_go, end_int, cap_on_r, cap_done;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    gcnt_nxt = gcnt_r;
    extra_nxt = extra_r;
    cont_nxt = cont_r;
    ready_nxt = ready_r;
    req_nxt = req_r;
    keep_go = 1'b0;
    end_int = 1'b0;
    if (cmd_rel) ready_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        cnt_nxt = 32'h00000000;
        gcnt_nxt = 9'h000;
        cont_nxt = 1'b1;
        extra_nxt = `CCDT_SCANS_PER_REQ;
        case (mode_r)
          MODE_FREE: begin
            if (req_r && !ready_r) st_nxt = ST_GATE;
          end
          MODE_SOFT: st_nxt = ST_GATE;
          MODE_SYNC, MODE_LEVEL, MODE_EDGE: begin
            // an unread spectrum blocks a new triggered start from idle
            if (trig_rise && !ready_r) st_nxt = ST_DELAY;
          end
          default: st_nxt = ST_IDLE;
        endcase
      end
      ST_DELAY: begin
        if (cnt_r[15:0] == tdly_r) begin
          st_nxt = ST_GATE;
          cnt_nxt = 32'h00000000;
        end else if (tick_r) begin
          cnt_nxt = cnt_r + 32'h00000001;
        end
      end
      ST_GATE: begin
        gcnt_nxt = gcnt_r + 9'h001;
        if (gcnt_r == 9'(`CCDT_GATE_CYC - 1)) begin
          gcnt_nxt = 9'h000;
          cnt_nxt = 32'h00000000;
          st_nxt = cont_r ? ST_INTEG : ST_IDLE;
        end
      end
      ST_INTEG: begin
        if (mode_r == MODE_SYNC) begin
          end_int = trig_rise;
        end else begin
          end_int = tick_r && (cnt_r + 32'h00000001 >= int_r);
        end
        if (tick_r) cnt_nxt = cnt_r + 32'h00000001;
        if (end_int) begin
          // hand over only when asked and the memory is free
          keep_go = req_r && !ready_r && !cap_on_r &&
            (mode_r != MODE_SOFT || trig_s2_r);
          if (keep_go) req_nxt = 1'b0;
          st_nxt = ST_GATE;
          case (mode_r)
            MODE_FREE: begin
              extra_nxt = extra_r - 2'h1;
              cont_nxt = (extra_r != 2'h1);
            end
            MODE_SOFT: cont_nxt = 1'b1;
            MODE_SYNC: cont_nxt = 1'b1;
            MODE_LEVEL: cont_nxt = trig_s2_r;
            MODE_EDGE: cont_nxt = 1'b0;
            default: cont_nxt = 1'b0;
          endcase
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (cmd_req) req_nxt = 1'b1;
    if (cap_done) ready_nxt = 1'b1;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'h00000000;
      gcnt_r <= 9'h000;
      extra_r <= 2'h0;
      cont_r <= 1'b0;
      ready_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      gcnt_r <= gcnt_nxt;
      extra_r <= extra_nxt;
      cont_r <= cont_nxt;
      ready_r <= ready_nxt;
      req_r <= req_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pixel capture into the spectrum memory
  // ----------------------------------------------------------------
  logic cap_on_nxt;
  logic [11:0] elem_r, elem_nxt;

  // the stream after a closing gate carries the integration just ended
  always_comb begin
    cap_on_nxt = cap_on_r;
    elem_nxt = elem_r;
    cap_done = 1'b0;
    u_mif.wr_en = 1'b0;
    u_mif.wr_addr = pix_map(elem_r);
    u_mif.wr_data = i_pix_data;
    u_mif.rd_addr = paddr_nxt;
    if (keep_go) begin
      cap_on_nxt = 1'b1;
      elem_nxt = 12'h000;
    end else if (cap_on_r && i_pix_valid) begin
      // shielded start to 2048th pixel after it; rest discarded
      u_mif.wr_en = (elem_r >= `CCDT_ELEM_FIRST) &&
        (elem_r - `CCDT_ELEM_FIRST <= `CCDT_SPEC_LAST);
      elem_nxt = elem_r + 12'h001;
      if (elem_r == `CCDT_ELEM_LAST) begin
        cap_on_nxt = 1'b0;
        cap_done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cap_on_r <= 1'b0;
      elem_r <= 12'h000;
    end else begin
      cap_on_r <= cap_on_nxt;
      elem_r <= elem_nxt;
    end
  end

  ccdt_mem #(.AW(PIX_AW), .DW(PIX_DW)) u_mem (
    .i_mclk(i_mclk),
    .bus(u_mif.mem)
  );

  // ----------------------------------------------------------------
  // readout gate and single strobe
  // ----------------------------------------------------------------
  logic gate_r, gate_nxt, start_r, start_nxt, run_r, run_nxt;
  logic [16:0] scnt_r, scnt_nxt;
  logic single_r, single_nxt, lampo_r;

  // strobe counts ticks from the gate rising edge in every mode
  always_comb begin
    gate_nxt = (st_nxt == ST_GATE);
    start_nxt = gate_nxt && !gate_r;
    run_nxt = run_r || start_r;
    scnt_nxt = scnt_r;
    if (start_r) begin
      scnt_nxt = 17'h00000;
    end else if (tick_r && scnt_r != `CCDT_STROBE_SAT) begin
      scnt_nxt = scnt_r + 17'h00001;
    end
    single_nxt = lamp_r && run_nxt && !start_r &&
      (scnt_nxt >= {1'b0, rise_r}) &&
      (scnt_nxt < {1'b0, fall_r});
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gate_r <= 1'b0;
      start_r <= 1'b0;
      run_r <= 1'b0;
      scnt_r <= `CCDT_STROBE_SAT;
      single_r <= 1'b0;
      lampo_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
      start_r <= start_nxt;
      run_r <= run_nxt;
      scnt_r <= scnt_nxt;
      single_r <= single_nxt;
      lampo_r <= lamp_nxt;
    end
  end

  ccdt_cstrobe #(.PW(CPER_W)) u_cstrobe (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_tick(tick_r),
    .i_period(cper_r),
    .i_lamp(lamp_r),
    .o_strobe(o_strobe_cont)
  );

  // all outputs leave straight from flops
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_readout_gate = gate_r;
  assign o_integration_start = start_r;
  assign o_strobe_single = single_r;
  assign o_lamp_en = lampo_r;
endmodule : ccdt_top
`default_nettype wire

// file: ccdt_top_checker.sv
// port assertions for the acquisition controller
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_cfg.svh"
module ccdt_top_checker #(
  parameter int PIX_AW = 11,
  parameter int PIX_DW = 14,
  parameter int CPER_W = 27
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_trig,
  input wire logic i_pix_valid,
  input wire logic [PIX_DW-1:0] i_pix_data,
  input wire logic o_readout_gate,
  input wire logic o_integration_start,
  input wire logic o_strobe_single,
  input wire logic o_strobe_cont,
  input wire logic o_lamp_en
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic wr_acc;
  logic [CPER_W-1:0] per;
  logic [8:0] gcnt_r, gcnt_nxt;
  logic [31:0] ccnt_r, ccnt_nxt, half_r, half_nxt;
  logic cs_r, cs_nxt;
  logic [1:0] ok_r, ok_nxt;
  // period shadow follows apb writes; short periods clamp to the minimum
  assign wr_acc = i_psel && i_penable && i_pwrite && !o_pready;
  assign per = (i_pwdata[CPER_W-1:0] < `CCDT_CSTROBE_MIN) ?
    CPER_W'(`CCDT_CSTROBE_MIN) : i_pwdata[CPER_W-1:0];
  // half periods are only judged after two edges, so a restart is ignored
  always_comb begin
    gcnt_nxt = o_readout_gate ? gcnt_r + 9'h001 : 9'h000;
    cs_nxt = o_strobe_cont;
    ccnt_nxt = (cs_r != o_strobe_cont) ? 32'h1 : ccnt_r + 32'h1;
    ok_nxt = ok_r;
    if (cs_r != o_strobe_cont && ok_r != 2'h2) ok_nxt = ok_r + 2'h1;
    half_nxt = half_r;
    if (wr_acc && i_paddr == `CCDT_OFS_CPER) begin
      half_nxt = 32'(per >> 1) * `CCDT_TICK_CYC;
      ok_nxt = 2'h0;
    end
    if (!o_lamp_en) ok_nxt = 2'h0;
  end
  // helper registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gcnt_r <= 9'h000;
      ccnt_r <= 32'h0;
      half_r <= 32'(`CCDT_CPER_RST >> 1) * `CCDT_TICK_CYC;
      cs_r <= 1'b0;
      ok_r <= 2'h0;
    end else begin
      gcnt_r <= gcnt_nxt;
      ccnt_r <= ccnt_nxt;
      half_r <= half_nxt;
      cs_r <= cs_nxt;
      ok_r <= ok_nxt;
    end
  end
  lamp_follow_a: assert property (
    wr_acc && i_paddr == `CCDT_OFS_CTRL |=>
    o_lamp_en == $past(i_pwdata[`CCDT_CTRL_LAMP])) else $error("lamp bad");
  single_gated_a: assert property (
    !o_lamp_en && !$past(o_lamp_en) |-> !o_strobe_single)
    else $error("single strobe without lamp");
  cont_gated_a: assert property (
    !o_lamp_en && !$past(o_lamp_en) |-> !o_strobe_cont)
    else $error("cont strobe without lamp");
  gate_len_a: assert property (
    $fell(o_readout_gate) |-> gcnt_r == 9'(`CCDT_GATE_CYC))
    else $error("gate length wrong");
  start_after_gate_a: assert property (
    $rose(o_readout_gate) |-> o_integration_start ##1 !o_integration_start)
    else $error("start pulse missing");
  start_cause_a: assert property (
    o_integration_start |-> o_readout_gate &&
    !$past(o_readout_gate)) else $error("start pulse stray");
  cont_half_a: assert property (
    cs_r != o_strobe_cont && ok_r == 2'h2 |-> ccnt_r == half_r)
    else $error("cont strobe half period wrong");
  apb_wait_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer timing");
  unmapped_a: assert property (
    o_pready && o_pslverr |-> o_prdata == 32'h0) else $error("error data");
endmodule : ccdt_top_checker
bind ccdt_top ccdt_top_checker #(.PIX_AW(PIX_AW), .PIX_DW(PIX_DW),
  .CPER_W(CPER_W)) u_ccdt_top_checker (.i_mclk, .i_rst, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
  .o_pslverr, .i_trig, .i_pix_valid, .i_pix_data, .o_readout_gate,
  .o_integration_start, .o_strobe_single, .o_strobe_cont, .o_lamp_en);
`default_nettype wire

// file: ccdt_partner.sv
// trigger source and detector readout model
`timescale 1ns/1ps
`default_nettype none
module ccdt_partner (
  input wire logic i_mclk,
  input wire logic i_gate,
  output logic o_trig,
  output logic o_pix_valid,
  output logic [13:0] o_pix_data
);
  initial begin
    o_trig = 1'b0;
    o_pix_valid = 1'b0;
    o_pix_data = 14'h0000;
  end
  // one trigger pulse, moved just after a clock edge
  task automatic pulse(input int hi);
    @(posedge i_mclk);
    o_trig <= 1'b1;
    repeat (hi) @(posedge i_mclk);
    o_trig <= 1'b0;
  endtask : pulse
  // every transfer is read out whole; data flips between strobes
  initial begin
    forever begin
      @(negedge i_gate);
      for (int e = 0; e < 2086; e++) begin
        @(posedge i_mclk);
        o_pix_valid <= 1'b1;
        o_pix_data <= 14'(e) ^ 14'h1555;
        @(posedge i_mclk);
        o_pix_valid <= 1'b0;
        o_pix_data <= ~(14'(e) ^ 14'h1555);
      end
    end
  end
endmodule : ccdt_partner
`default_nettype wire

// file: tb_ccd_acquisition_trigger_strobe.sv
// self-checking bench for the acquisition controller
`timescale 1ns/1ps
`default_nettype none
`include "ccdt_cfg.svh"
module tb_ccd_acquisition_trigger_strobe;
  import ccdt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, gate_q = 1'b0, ss_q = 1'b0, tr_q = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, trig, pix_valid, gate, istart, ss, cs, lamp;
  logic [13:0] pix_data;
  int fail_count = 0, tests_run = 0, gates = 0, t_now = 0, t_st = 0;
  int t_up = 0, t_dn = 0, t_tr = 0, t_g1 = 0, ncs = 0;
  logic cs_q = 1'b0;
  always #12.5 clk = ~clk;
  ccdt_top u_ccdt_top (.i_mclk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_trig(trig), .i_pix_valid(pix_valid),
    .i_pix_data(pix_data), .o_readout_gate(gate),
    .o_integration_start(istart), .o_strobe_single(ss),
    .o_strobe_cont(cs), .o_lamp_en(lamp));
  ccdt_partner u_ccdt_partner (.i_mclk(clk), .i_gate(gate), .o_trig(trig),
    .o_pix_valid(pix_valid), .o_pix_data(pix_data));
  // cycle stamps of trigger, gates, start pulses and strobe edges
  always @(posedge clk) begin
    t_now <= t_now + 1;
    gate_q <= gate;
    ss_q <= ss;
    tr_q <= trig;
    cs_q <= cs;
    if (cs != cs_q) ncs <= ncs + 1;
    if (gate && !gate_q) gates <= gates + 1;
    if (gate && !gate_q && t_g1 < t_tr) t_g1 <= t_now;
    if (trig && !tr_q) t_tr <= t_now;
    if (istart) t_st <= t_now;
    if (ss && !ss_q) t_up <= t_now;
    if (!ss && ss_q) t_dn <= t_now;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk(32'(n < 40), 32'h1);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  // polls status under a bounded count, then judges it
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(`CCDT_OFS_STAT, q);
      n++;
    end while ((q & m) !== v && n < 6000);
    chk(q & m, v);
  endtask : wait_stat
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(`CCDT_OFS_INT, q);
    chk(q, `CCDT_INT_RST);
    rd(`CCDT_OFS_CPER, q);
    chk(q, 32'(`CCDT_CPER_RST));
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    for (int m = 0; m < 5; m++) begin
      wr(`CCDT_OFS_CTRL, 32'(m));
      rd(`CCDT_OFS_CTRL, q);
      chk(q, 32'(m));
    end
    wr(`CCDT_OFS_RISE, 32'h00012345);
    rd(`CCDT_OFS_RISE, q);
    chk(q, 32'h00002345);
    wr(`CCDT_OFS_CTRL, 32'h8);
    chk({31'h0, lamp}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_free;
    logic [31:0] q;
    logic [10:0] ix[3] = '{11'h000, 11'h011, 11'h7FF};
    wr(`CCDT_OFS_CTRL, 32'(MODE_FREE));
    wr(`CCDT_OFS_INT, 32'h000000F8);
    wr(`CCDT_OFS_CMD, 32'h1);
    wait_stat(32'h1, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(`CCDT_OFS_PADDR, 32'(ix[i]));
      rd(`CCDT_OFS_PDATA, q);
      chk(q, 32'(14'(32'(ix[i]) + 32'hC) ^ 14'h1555));
    end
    wr(`CCDT_OFS_CMD, 32'h2);
    wait_stat(32'hD, 32'h0);
    $display("test free done");
  endtask : t_free
  task automatic t_edge;
    int g;
    logic [31:0] q;
    wr(`CCDT_OFS_CTRL, 32'(MODE_EDGE) | 32'h8);
    wr(`CCDT_OFS_TDLY, 32'h3);
    wr(`CCDT_OFS_RISE, 32'h2);
    wr(`CCDT_OFS_FALL, 32'h5);
    wr(`CCDT_OFS_CMD, 32'h1);
    g = gates;
    u_ccdt_partner.pulse(12000);
    wait_stat(32'h1, 32'h1);
    chk(32'(gates - g), 32'h2);
    chk(32'(t_g1 - t_tr >= 45 && t_g1 - t_tr <= 68), 32'h1);
    chk(32'(t_up - t_st >= 19 && t_up - t_st <= 42), 32'h1);
    chk(32'(t_dn - t_up), 32'h3C);
    wr(`CCDT_OFS_CMD, 32'h2);
    wait_stat(32'hC, 32'h0);
    u_ccdt_partner.pulse(200);
    wait_stat(32'hD, 32'h0);
    // a dropped scan must stay dropped after its pixels have streamed
    repeat (4400) @(posedge clk);
    rd(`CCDT_OFS_STAT, q);
    chk(q & 32'h1, 32'h0);
    $display("test edge done");
  endtask : t_edge
  task automatic t_level;
    int g;
    wr(`CCDT_OFS_CTRL, 32'(MODE_LEVEL) | 32'h8);
    g = gates;
    u_ccdt_partner.pulse(12000);
    wait_stat(32'hC, 32'h0);
    chk(32'(gates - g >= 3), 32'h1);
    // 2 tick half period: any 400 cycle window holds ten edges
    g = ncs;
    repeat (400) @(posedge clk);
    chk(32'(ncs - g), 32'hA);
    $display("test level done");
  endtask : t_level
  // second trigger edge must close the scan long before int count
  task automatic t_sync;
    int g;
    wr(`CCDT_OFS_CTRL, 32'(MODE_SYNC) | 32'h8);
    g = gates;
    u_ccdt_partner.pulse(10);
    repeat (2000) @(posedge clk);
    u_ccdt_partner.pulse(10);
    repeat (400) @(posedge clk);
    chk(32'(gates - g), 32'h2);
    $display("test sync done");
  endtask : t_sync
  // watchdog sized well beyond the expected run
  initial begin
    #2375000;
    fail_count++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_free;
    t_edge;
    t_level;
    t_sync;
    conclude;
  end
endmodule : tb_ccd_acquisition_trigger_strobe
`default_nettype wire
